// ---- bench/pbc_an_core_model.sv ----
/*
  Stand-in for the auto-negotiation core beside the basic control register.
  Assumes the register's clock and its one-cycle an_restart pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module pbc_an_core_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic an_restart,
  input  wire logic want_100,
  input  wire logic want_full,
  output var  logic an_result_100,
  output var  logic an_result_full,
  output var  int   restarts
);
  // ==========================================================================
  // Negotiation timing
  int busy_cnt;

  // count restarts, renegotiate for a while
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= 0;
      restarts <= 0;
    end else if (an_restart) begin
      busy_cnt <= 4;
      restarts <= restarts + 1;
    end else if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end

  // results read low until settled, a slow answer
  assign an_result_100  = (busy_cnt == 0) && want_100;
  assign an_result_full = (busy_cnt == 0) && want_full;
endmodule : pbc_an_core_model
`default_nettype wire

// ---- bench/phy_basic_control_register_tb.sv ----
/*
  Self-checking bench for the basic control register with a register model.
  Assumes the one-cycle register port and the core stand-in model.
*/
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_register_tb;
  import pbc_pkg::*;
  // ==========================================================================
  // Signals and model state
  logic        clk_sys, sys_rst, reg_wr, reg_rd, chip_reset, an_restart;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic        s_rate, s_an, s_iso, s_fh, want_100, want_full, r100, rfull;
  logic        loopback_en, power_down, mac_detach, clash_test_en;
  logic        link_rate_100, link_full_duplex;
  int          err_total, check_count, m, n_rst, restarts;

  pbc_basic_ctrl pbc_basic_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rate_select_strap(s_rate), .autoneg_strap(s_an),
    .mac_detach_strap(s_iso), .full_half_strap(s_fh), .an_result_100(r100),
    .an_result_full(rfull), .chip_reset(chip_reset), .an_restart(an_restart),
    .loopback_en(loopback_en), .power_down(power_down), .mac_detach(mac_detach),
    .clash_test_en(clash_test_en), .link_rate_100(link_rate_100),
    .link_full_duplex(link_full_duplex));
  pbc_an_core_model pbc_an_core_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .an_restart(an_restart), .want_100(want_100), .want_full(want_full),
    .an_result_100(r100), .an_result_full(rfull), .restarts(restarts));

  // Clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Compare tasks
  task automatic chk_rd(input logic [15:0] got, input int exp);
    check_count++;
    if (got !== exp[15:0]) begin
      err_total++;
      $display("Error %0t value %h expected %h", $time, got, exp[15:0]);
    end
  endtask : chk_rd

  task automatic chk_out;
    logic [5:0] e;
    e = {m[14], m[11], m[10], m[7], m[12] ? want_100 : m[13], m[12] ? want_full : m[8]};
    check_count++;
    if ({loopback_en, power_down, mac_detach, clash_test_en, link_rate_100,
         link_full_duplex} !== e) begin
      err_total++;
      $display("Error %0t control outputs differ, expected %b", $time, e);
    end
  endtask : chk_out

  function automatic int strap_val();
    return (int'(s_rate) << 13) | (int'(s_an) << 12) | (int'(s_iso) << 10) | (int'(!s_fh) << 8);
  endfunction : strap_val

  // Register model for one write; returns whether a chip reset follows
  function automatic logic mdl_wr(input logic [4:0] a, input logic [15:0] v);
    logic cr;
    cr = 1'b0;
    if (a == 5'h00) begin
      cr = v[15] && !m[11];
      if (v[9] && v[12]) n_rst++;
      if (v[15] && m[11]) m = m & 'h77FF;
      else if (v[15]) m = strap_val();
      else m = v & 'h7D80;
    end
    return cr;
  endfunction : mdl_wr

  // ==========================================================================
  // Bus tasks; a write also steps the model
  task automatic rd(input logic [4:0] a, input int exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk_rd(reg_rdata, exp);
  endtask : rd

  task automatic put(input logic [4:0] a, input logic [15:0] v);
    logic cr;
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    cr = mdl_wr(a, v);
    @(posedge clk_sys);
    #1 chk_rd({15'h0000, chip_reset}, cr);
    repeat (15) @(posedge clk_sys);
    #1 chk_out;
  endtask : put

  // Two writes on back-to-back strobes, checked after the second
  task automatic put_pair(input logic [15:0] v1, input logic [15:0] v2);
    logic cr;
    @(posedge clk_sys);
    reg_addr  <= 5'h00;
    reg_wdata <= v1;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wdata <= v2;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    void'(mdl_wr(5'h00, v1));
    cr = mdl_wr(5'h00, v2);
    @(posedge clk_sys);
    #1 chk_rd({15'h0000, chip_reset}, cr);
    repeat (15) @(posedge clk_sys);
    #1 chk_out;
  endtask : put_pair

  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Watchdog, far beyond the few hundred cycles expected
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(95234));
    {reg_wr, reg_rd, reg_addr, reg_wdata, err_total, check_count, n_rst} = '0;
    {s_rate, s_an, s_iso, s_fh, want_100, want_full} = 6'($urandom);
    sys_rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (14) @(posedge clk_sys);
    m = strap_val();
    #1 chk_out;
    rd(5'h00, m);
    for (int i = 0; i < 10; i++) begin
      d = 16'($urandom);
      d[15] = 1'b0;
      {want_100, want_full} <= 2'($urandom);
      put(5'h00, d);
      rd(5'h00, m);
    end
    put(5'h00, 16'h1A00);
    chk_rd(restarts[15:0], n_rst);
    {s_rate, s_an, s_iso, s_fh} <= ~{s_rate, s_an, s_iso, s_fh};
    put(5'h00, 16'(m) | 16'h8000);
    rd(5'h00, m);
    put(5'h00, 16'h8000);
    rd(5'h00, m);
    put(5'h01, 16'hFFFF);
    rd(5'h01, 0);
    rd(5'h00, m);
    put_pair(16'h4880, 16'h8000);
    rd(5'h00, m);
    report_and_stop();
  end
endmodule : phy_basic_control_register_tb
`default_nettype wire

// ---- hdl/pbc_basic_ctrl.sv ----
/*
  Basic control register of a 10/100 transceiver: soft reset, loopback,
  rate, duplex, auto-negotiation, power-down, isolate and clash test.
  Assumes strap pins are asynchronous levels and a one-clock register port.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Writing one to bit 15 starts a soft reset and the bit clears itself, reading zero.
// - Bit 13 forces 100 Mbps when one, 10 Mbps when zero, ignored with auto-negotiation on.
// - After reset the rate bit takes the latched rate strap level.
// - Bit 12 enables auto-negotiation, whose result overrides the rate and duplex bits.
// - After reset the auto-negotiation enable takes the latched autoneg strap level.
// - Bit 11 selects power-down when set, normal when clear, and resets to zero.
// - Leaving power-down by soft reset takes two writes: first clears power-down, second resets.
// - Bit 10 set detaches the transceiver from the MAC interface.
// - After reset the isolate bit takes the latched detach strap level.
// - Writing one to bit 9 together with bit 12 restarts auto-negotiation and the bit clears itself.
// - Bit 8 selects full duplex, resetting to the inverse of the duplex strap level.
module pbc_basic_ctrl
  import pbc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [PBC_ADDR_W-1:0] reg_addr,
  input  wire logic [PBC_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [PBC_DATA_W-1:0] reg_rdata,
  input  wire logic                  rate_select_strap,
  input  wire logic                  autoneg_strap,
  input  wire logic                  mac_detach_strap,
  input  wire logic                  full_half_strap,
  input  wire logic                  an_result_100,
  input  wire logic                  an_result_full,
  output var  logic                  chip_reset,
  output var  logic                  an_restart,
  output var  logic                  loopback_en,
  output var  logic                  power_down,
  output var  logic                  mac_detach,
  output var  logic                  clash_test_en,
  output var  logic                  link_rate_100,
  output var  logic                  link_full_duplex
);

  // ==========================================================================
  // Strap synchronisers
  pbc_strap_type strap_meta_reg;
  pbc_strap_type strap_sync_reg;

  // Straps come from pins; two flops before any use
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= {rate_select_strap, autoneg_strap, mac_detach_strap, full_half_strap};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ==========================================================================
  // Chip reset sequencing
  typedef enum logic [2:0] {
    PBC_ST_RESET = 3'b001,
    PBC_ST_LATCH = 3'b010,
    PBC_ST_RUN   = 3'b100
  } pbc_state_type;

  pbc_state_type state_reg;
  pbc_state_type state_next;
  logic [3:0]    rst_cnt_reg;
  logic          wr_ctrl;
  logic          soft_rst_req;
  logic          wake_req;
  pbc_ctrl_type  ctrl_reg;

  assign wr_ctrl      = reg_wr && (reg_addr == PBC_ADDR_CTRL) && (state_reg == PBC_ST_RUN);
  // first reset write while powered down only wakes
  // Stored bit, not the output flop, so a write right after power-down sees it
  assign soft_rst_req = wr_ctrl && reg_wdata[PBC_BIT_RST] && !ctrl_reg.power_down;
  // reset write while powered down clears power-down and no other control bit
  assign wake_req     = wr_ctrl && reg_wdata[PBC_BIT_RST] && ctrl_reg.power_down;

  // Sequencer: reset hold, strap latch, run
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PBC_ST_RESET: begin
        if (rst_cnt_reg == 4'h0) begin
          state_next = PBC_ST_LATCH;
        end
      end
      PBC_ST_LATCH: begin
        state_next = PBC_ST_RUN;
      end
      PBC_ST_RUN: begin
        if (soft_rst_req) begin
          state_next = PBC_ST_RESET;
        end
      end
      default: begin
        state_next = PBC_ST_RESET;
      end
    endcase
  end

  // Hold state long enough for the strap synchronisers to fill
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= PBC_ST_RESET;
      rst_cnt_reg <= PBC_CHIP_RST_CYC;
    end else begin
      state_reg <= state_next;
      if (state_next == PBC_ST_RESET && state_reg != PBC_ST_RESET) begin
        rst_cnt_reg <= PBC_CHIP_RST_CYC;
      end else if (rst_cnt_reg != 4'h0) begin
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      end
    end
  end

  // Chip reset out, high throughout the reset state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chip_reset <= 1'b1;
    end else begin
      chip_reset <= (state_next == PBC_ST_RESET);
    end
  end

  // ==========================================================================
  // Control bits
  // Bits a wake-up write must leave alone, watched by the checks below
  logic [5:0]   ctrl_keep;

  assign ctrl_keep = {ctrl_reg.loopback, ctrl_reg.rate_100, ctrl_reg.autoneg_en,
                      ctrl_reg.mac_detach, ctrl_reg.duplex_full, ctrl_reg.clash_test};

  // Register write, cleared in chip reset and loaded from straps after it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
    end else if (state_reg == PBC_ST_RESET) begin
      ctrl_reg <= '0;
    end else if (state_reg == PBC_ST_LATCH) begin
      ctrl_reg.rate_100    <= strap_sync_reg.rate;
      ctrl_reg.autoneg_en  <= strap_sync_reg.autoneg;
      ctrl_reg.mac_detach  <= strap_sync_reg.detach;
      ctrl_reg.duplex_full <= ~strap_sync_reg.full_half;
      ctrl_reg.loopback    <= 1'b0;
      ctrl_reg.power_down  <= 1'b0;
      ctrl_reg.clash_test  <= 1'b0;
    end else if (wake_req) begin
      ctrl_reg.power_down  <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_reg.loopback    <= reg_wdata[PBC_BIT_LOOP];
      ctrl_reg.rate_100    <= reg_wdata[PBC_BIT_RATE];
      ctrl_reg.autoneg_en  <= reg_wdata[PBC_BIT_ANEN];
      // power-down; kept low on a soft reset write so the pin stays quiet
      ctrl_reg.power_down  <= reg_wdata[PBC_BIT_RST] ? 1'b0 : reg_wdata[PBC_BIT_PDOWN];
      ctrl_reg.mac_detach  <= reg_wdata[PBC_BIT_ISO];
      ctrl_reg.duplex_full <= reg_wdata[PBC_BIT_DUPLEX];
      ctrl_reg.clash_test  <= reg_wdata[PBC_BIT_COLTST];
    end
  end

  // ==========================================================================
  // Outputs toward the transceiver core
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      loopback_en      <= 1'b0;
      power_down       <= 1'b0;
      mac_detach       <= 1'b0;
      clash_test_en    <= 1'b0;
      link_rate_100    <= 1'b0;
      link_full_duplex <= 1'b0;
    end else begin
      loopback_en      <= ctrl_reg.loopback;
      power_down       <= ctrl_reg.power_down;
      mac_detach       <= ctrl_reg.mac_detach;
      clash_test_en    <= ctrl_reg.clash_test;
      link_rate_100    <= ctrl_reg.autoneg_en ? an_result_100 : ctrl_reg.rate_100;
      link_full_duplex <= ctrl_reg.autoneg_en ? an_result_full : ctrl_reg.duplex_full;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= wr_ctrl && reg_wdata[PBC_BIT_ANRST] && reg_wdata[PBC_BIT_ANEN];
    end
  end

  // ==========================================================================
  // Read port
  function automatic logic [PBC_DATA_W-1:0] pack_ctrl(input pbc_ctrl_type c);
    logic [PBC_DATA_W-1:0] v;
    v                 = '0;
    v[PBC_BIT_LOOP]   = c.loopback;
    v[PBC_BIT_RATE]   = c.rate_100;
    v[PBC_BIT_ANEN]   = c.autoneg_en;
    v[PBC_BIT_PDOWN]  = c.power_down;
    v[PBC_BIT_ISO]    = c.mac_detach;
    v[PBC_BIT_DUPLEX] = c.duplex_full;
    v[PBC_BIT_COLTST] = c.clash_test;
    return v;
  endfunction : pack_ctrl

  // self-clear and reserved bits read zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= PBC_RD_UNMAPPED;
    end else if (reg_rd && reg_addr == PBC_ADDR_CTRL) begin
      reg_rdata <= pack_ctrl(ctrl_reg);
    end else begin
      reg_rdata <= PBC_RD_UNMAPPED;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_reset_write;
    wr_ctrl && reg_wdata[PBC_BIT_RST] && !ctrl_reg.power_down;
  endsequence

  sequence s_wake_write;
    wr_ctrl && reg_wdata[PBC_BIT_RST] && ctrl_reg.power_down;
  endsequence

  // Chip reset holds nine cycles before the strap latch cycle
  sequence s_reset_hold;
    chip_reset [*8] ##1 chip_reset;
  endsequence

  a_soft_reset_start: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_reset_write |=> chip_reset)
    else $error("soft reset write did not raise chip reset");

  a_reset_reads_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd |=> !reg_rdata[PBC_BIT_RST] && !reg_rdata[PBC_BIT_ANRST])
    else $error("self-clearing bit read as one");

  a_rate_forced: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !ctrl_reg.autoneg_en |=> link_rate_100 == $past(ctrl_reg.rate_100))
    else $error("forced rate not applied");

  a_an_overrides: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ctrl_reg.autoneg_en |=> link_full_duplex == $past(an_result_full))
    else $error("negotiated duplex not applied");

  a_strap_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    state_reg == PBC_ST_LATCH |=> ctrl_reg.rate_100 == $past(strap_sync_reg.rate)
      && ctrl_reg.autoneg_en == $past(strap_sync_reg.autoneg))
    else $error("rate or autoneg strap not latched");

  a_detach_duplex: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    state_reg == PBC_ST_LATCH |=> ctrl_reg.mac_detach == $past(strap_sync_reg.detach)
      && ctrl_reg.duplex_full == !$past(strap_sync_reg.full_half))
    else $error("detach or duplex strap not latched");

  a_wake_first: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_wake_write |=> !chip_reset ##1 !power_down)
    else $error("first reset write while powered down did not only wake");

  a_restart_pulse: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !(wr_ctrl && reg_wdata[PBC_BIT_ANRST] && reg_wdata[PBC_BIT_ANEN]) |=> !an_restart)
    else $error("restart pulse without a restart write");

  a_restart_fires: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && reg_wdata[PBC_BIT_ANRST] && reg_wdata[PBC_BIT_ANEN] |=> an_restart)
    else $error("restart write gave no restart pulse");

  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd |=> reg_rdata[6:0] == 7'h00)
    else $error("reserved bits read nonzero");

  a_chip_reset_len: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_reset_write |=> s_reset_hold ##1 !chip_reset)
    else $error("chip reset length wrong");

  a_wake_keeps: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_wake_write |=> $stable(ctrl_keep))
    else $error("wake-up write changed other control bits");

  a_pdown_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && !reg_wdata[PBC_BIT_RST]
      |=> ##1 power_down == $past(reg_wdata[PBC_BIT_PDOWN], 2))
    else $error("power-down output does not follow write");

  a_detach_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && !reg_wdata[PBC_BIT_RST]
      |=> ##1 mac_detach == $past(reg_wdata[PBC_BIT_ISO], 2))
    else $error("detach output does not follow write");

  a_loop_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && !reg_wdata[PBC_BIT_RST]
      |=> ##1 loopback_en == $past(reg_wdata[PBC_BIT_LOOP], 2))
    else $error("loopback output does not follow write");

  a_clash_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_ctrl && !reg_wdata[PBC_BIT_RST]
      |=> ##1 clash_test_en == $past(reg_wdata[PBC_BIT_COLTST], 2))
    else $error("clash test output does not follow write");

  a_reset_clears: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    state_reg == PBC_ST_LATCH |=> !ctrl_reg.power_down && !ctrl_reg.loopback
      && !ctrl_reg.clash_test)
    else $error("power-down, loopback or clash test not cleared by reset");

  a_duplex_forced: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !ctrl_reg.autoneg_en |=> link_full_duplex == $past(ctrl_reg.duplex_full))
    else $error("forced duplex not applied");

  a_rate_negotiated: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ctrl_reg.autoneg_en |=> link_rate_100 == $past(an_result_100))
    else $error("negotiated rate not applied");

endmodule : pbc_basic_ctrl

`default_nettype wire

// ---- hdl/pbc_pkg.sv ----
/*
  Constants and carrier types for the transceiver basic control register.
  Assumes a single 125 MHz system clock and a plain register port.
*/
package pbc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0]  PBC_ADDR_CTRL   = 5'h00;
  localparam int          PBC_ADDR_W      = 5;
  localparam int          PBC_DATA_W      = 16;

  // ==========================================================================
  // Field positions
  localparam int          PBC_BIT_RST     = 15;
  localparam int          PBC_BIT_LOOP    = 14;
  localparam int          PBC_BIT_RATE    = 13;
  localparam int          PBC_BIT_ANEN    = 12;
  localparam int          PBC_BIT_PDOWN   = 11;
  localparam int          PBC_BIT_ISO     = 10;
  localparam int          PBC_BIT_ANRST   = 9;
  localparam int          PBC_BIT_DUPLEX  = 8;
  localparam int          PBC_BIT_COLTST  = 7;

  // ==========================================================================
  // Reset values and timing
  localparam logic [15:0] PBC_RD_UNMAPPED = 16'h0000;
  localparam logic        PBC_RST_ZERO    = 1'b0;
  localparam logic [3:0]  PBC_CHIP_RST_CYC = 4'h8;

  // Control bits as seen by the rest of the transceiver
  typedef struct packed {
    logic loopback;
    logic rate_100;
    logic autoneg_en;
    logic power_down;
    logic mac_detach;
    logic duplex_full;
    logic clash_test;
  } pbc_ctrl_type;

  // Latched strap levels
  typedef struct packed {
    logic rate;
    logic autoneg;
    logic detach;
    logic full_half;
  } pbc_strap_type;

endpackage : pbc_pkg
